// ===== crsx_core.v
// Execution datapath: rotate, subtract, swap, xor, direction load and sleep
`timescale 1ns/1ps
`include "crsx_regs.vh"
module crsx_core (
    clk,
    rst_n,
    op_valid,
    op_code,
    op_dest,
    op_addr,
    op_lit,
    file_rdata,
    wake_pin,
    file_we,
    file_waddr,
    file_wdata,
    w_reg,
    carry_flag,
    nibble_carry_flag,
    zero_flag,
    timeout_status_bit,
    powerdown_status_bit,
    watchdog_counter,
    wdt_prescaler,
    port_a_direction,
    port_b_direction,
    port_c_direction,
    osc_stop,
    sleeping
);
    input  wire       clk;
    input  wire       rst_n;
    input  wire       op_valid;
    input  wire [3:0] op_code;
    input  wire       op_dest;
    input  wire [6:0] op_addr;
    input  wire [7:0] op_lit;
    input  wire [7:0] file_rdata;
    input  wire       wake_pin;
    output reg        file_we;
    output reg  [6:0] file_waddr;
    output reg  [7:0] file_wdata;
    output reg  [7:0] w_reg;
    output reg        carry_flag;
    output reg        nibble_carry_flag;
    output reg        zero_flag;
    output reg        timeout_status_bit;
    output reg        powerdown_status_bit;
    output reg  [7:0] watchdog_counter;
    output reg  [7:0] wdt_prescaler;
    output reg  [7:0] port_a_direction;
    output reg  [7:0] port_b_direction;
    output reg  [7:0] port_c_direction;
    output reg        osc_stop;
    output reg        sleeping;

    // ----------------------------------------
    // Wake input and subtractor
    // ----------------------------------------
    wire       wake_s;
    wire [7:0] sub_a;
    wire [7:0] sub_b;
    wire       sub_cin;
    wire [7:0] sub_diff;
    wire       sub_c;
    wire       sub_dc;

    crsx_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (wake_pin),
        .q     (wake_s)
    );

    assign sub_a   = (op_code == `CRSX_OP_SUBL) ? op_lit : file_rdata;
    assign sub_b   = w_reg;
    assign sub_cin = (op_code == `CRSX_OP_SUBFB) ? carry_flag : 1'b1;

    crsx_sub u_sub (
        .a      (sub_a),
        .b      (sub_b),
        .cin    (sub_cin),
        .diff   (sub_diff),
        .carry  (sub_c),
        .ncarry (sub_dc)
    );

    // ----------------------------------------
    // Result selection
    // ----------------------------------------
    reg [7:0] res;
    reg       to_file;
    reg       upd_c;
    reg       upd_dc;
    reg       upd_z;
    reg       new_c;
    reg       wr_res;

    always @* begin
        res     = 8'h00;
        to_file = 1'b0;
        upd_c   = 1'b0;
        upd_dc  = 1'b0;
        upd_z   = 1'b0;
        new_c   = sub_c;
        wr_res  = 1'b0;
        case (op_code)
            `CRSX_OP_ROR: begin
                res     = {carry_flag, file_rdata[7:1]};
                new_c   = file_rdata[0];
                upd_c   = 1'b1;
                wr_res  = 1'b1;
                to_file = (op_dest == `CRSX_DEST_F);
            end
            `CRSX_OP_SUBL: begin
                res     = sub_diff;
                upd_c   = 1'b1;
                upd_dc  = 1'b1;
                upd_z   = 1'b1;
                wr_res  = 1'b1;
            end
            `CRSX_OP_SUBF, `CRSX_OP_SUBFB: begin
                res     = sub_diff;
                upd_c   = 1'b1;
                upd_dc  = 1'b1;
                upd_z   = 1'b1;
                wr_res  = 1'b1;
                to_file = (op_dest == `CRSX_DEST_F);
            end
            `CRSX_OP_SWAP: begin
                res     = {file_rdata[3:0], file_rdata[7:4]};
                wr_res  = 1'b1;
                to_file = (op_dest == `CRSX_DEST_F);
            end
            `CRSX_OP_XORL: begin
                res     = w_reg ^ op_lit;
                upd_z   = 1'b1;
                wr_res  = 1'b1;
            end
            `CRSX_OP_XORF: begin
                res     = w_reg ^ file_rdata;
                upd_z   = 1'b1;
                wr_res  = 1'b1;
                to_file = (op_dest == `CRSX_DEST_F);
            end
            default: begin
                res     = 8'h00;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    wire go;
    assign go = op_valid && !sleeping;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_we              <= 1'b0;
            file_waddr           <= 7'h00;
            file_wdata           <= 8'h00;
            w_reg                <= `CRSX_W_RST;
            carry_flag           <= 1'b0;
            nibble_carry_flag    <= 1'b0;
            zero_flag            <= 1'b0;
            timeout_status_bit   <= 1'b1;
            powerdown_status_bit <= 1'b1;
            watchdog_counter     <= `CRSX_WDT_CLR;
            wdt_prescaler        <= `CRSX_WDT_CLR;
            port_a_direction     <= `CRSX_DIR_RST;
            port_b_direction     <= `CRSX_DIR_RST;
            port_c_direction     <= `CRSX_DIR_RST;
            osc_stop             <= 1'b0;
            sleeping             <= 1'b0;
        end else begin
            file_we <= 1'b0;
            if (sleeping) begin
                if (wake_s) begin
                    sleeping <= 1'b0;
                    osc_stop <= 1'b0;
                end
            end else begin
                {wdt_prescaler, watchdog_counter} <= {wdt_prescaler, watchdog_counter} + 16'h0001;
            end
            if (go) begin
                if (wr_res) begin
                    if (to_file) begin
                        file_we    <= 1'b1;
                        file_waddr <= op_addr;
                        file_wdata <= res;
                    end else begin
                        w_reg <= res;
                    end
                end
                if (upd_c) begin
                    carry_flag <= new_c;
                end
                if (upd_dc) begin
                    nibble_carry_flag <= sub_dc;
                end
                if (upd_z) begin
                    zero_flag <= (res == 8'h00);
                end
                if (op_code == `CRSX_OP_DIR) begin
                    case (op_addr[2:0])
                        `CRSX_DIR_A: port_a_direction <= w_reg;
                        `CRSX_DIR_B: port_b_direction <= w_reg;
                        `CRSX_DIR_C: port_c_direction <= w_reg;
                        default: begin
                        end
                    endcase
                end
                if (op_code == `CRSX_OP_SLEEP) begin
                    watchdog_counter     <= `CRSX_WDT_CLR;
                    wdt_prescaler        <= `CRSX_WDT_CLR;
                    timeout_status_bit   <= 1'b1;
                    powerdown_status_bit <= 1'b0;
                    sleeping             <= 1'b1;
                    osc_stop             <= 1'b1;
                end
            end
        end
    end
endmodule // crsx_core

// ===== crsx_regs.vh
// Constants for the rotate/subtract/xor/sleep execution datapath
// Summary of operation
// - Rotate right through carry: low bit to carry, old carry to top; address 0..127.
// - Destination select 0 writes W, 1 writes back the file register.
// - Literal minus W in two's complement, result to W; literal 0..255.
// - Subtract: carry and nibble carry mean no borrow; zero also updated.
// - File minus W, difference to selected destination.
// - File minus W minus inverted carry; updates carry, nibble carry, zero.
// - Sleep clears watchdog and prescaler, sets time-out, clears power-down bit.
// - After sleep the core halts its oscillator and sleeps.
// - Nibble exchange swaps halves of the register, flags untouched.
// - Xor literal with W into W, only zero flag changes.
// - Xor file with W into destination, only zero flag changes.
// - Direction load copies W to port A, B, C direction for 5, 6, 7.
`ifndef CRSX_REGS_VH
`define CRSX_REGS_VH
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define CRSX_OP_NONE    4'h0
`define CRSX_OP_ROR     4'h1
`define CRSX_OP_SUBL    4'h2
`define CRSX_OP_SUBF    4'h3
`define CRSX_OP_SUBFB   4'h4
`define CRSX_OP_SWAP    4'h5
`define CRSX_OP_XORL    4'h6
`define CRSX_OP_XORF    4'h7
`define CRSX_OP_DIR     4'h8
`define CRSX_OP_SLEEP   4'h9
// ----------------------------------------
// Operands and reset values
// ----------------------------------------
`define CRSX_DIR_A      3'h5
`define CRSX_DIR_B      3'h6
`define CRSX_DIR_C      3'h7
`define CRSX_DIR_RST    8'hff
`define CRSX_W_RST      8'h00
`define CRSX_WDT_CLR    8'h00
`define CRSX_DEST_W     1'b0
`define CRSX_DEST_F     1'b1
`endif

// ===== crsx_sub.v
// Eight-bit subtractor with no-borrow carry and nibble carry
`timescale 1ns/1ps
`include "crsx_regs.vh"
module crsx_sub (
    a,
    b,
    cin,
    diff,
    carry,
    ncarry
);
    input  wire [7:0] a;
    input  wire [7:0] b;
    input  wire       cin;
    output wire [7:0] diff;
    output wire       carry;
    output wire       ncarry;

    // a + ~b + cin: carry set means no borrow
    wire [4:0] lo;
    wire [4:0] hi;
    assign lo     = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    assign hi     = {1'b0, a[7:4]} + {1'b0, ~b[7:4]} + {4'h0, lo[4]};
    assign diff   = {hi[3:0], lo[3:0]};
    assign carry  = hi[4];
    assign ncarry = lo[4];
endmodule // crsx_sub

// ===== crsx_sync.v
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module crsx_sync (
    clk,
    rst_n,
    d,
    q
);
    input  wire clk;
    input  wire rst_n;
    input  wire d;
    output wire q;

    reg s1_r;
    reg s2_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule // crsx_sync

// ===== crsx_asserts.sv
// Port assertions for the execution datapath
`timescale 1ns/1ps
`include "crsx_regs.vh"
module crsx_asserts (
    input       clk,
    input       rst_n,
    input       op_valid,
    input [3:0] op_code,
    input       op_dest,
    input [6:0] op_addr,
    input [7:0] op_lit,
    input [7:0] file_rdata,
    input       file_we,
    input [6:0] file_waddr,
    input [7:0] w_reg,
    input       carry_flag,
    input       nibble_carry_flag,
    input       zero_flag,
    input       timeout_status_bit,
    input       powerdown_status_bit,
    input [7:0] watchdog_counter,
    input [7:0] wdt_prescaler,
    input [7:0] port_a_direction,
    input       osc_stop,
    input       sleeping
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire       go  = op_valid && !sleeping;
    wire [7:0] swp = {file_rdata[3:0], file_rdata[7:4]};
    a_file_write: assert property (go && op_dest && op_code inside {`CRSX_OP_ROR, `CRSX_OP_SUBF, `CRSX_OP_SWAP}
        |=> file_we && file_waddr == $past(op_addr)) else $error("file write missing");
    a_w_dest: assert property (go && !op_dest && op_code inside {`CRSX_OP_SUBFB, `CRSX_OP_XORF} |=> !file_we)
        else $error("file written for W destination");
    a_ror_carry: assert property (go && op_code == `CRSX_OP_ROR |=> carry_flag == $past(file_rdata[0])
        && $stable(zero_flag) && $stable(nibble_carry_flag)) else $error("rotate flags wrong");
    a_subl_flags: assert property (go && op_code == `CRSX_OP_SUBL
        |=> carry_flag == ($past(w_reg) <= $past(op_lit)) && zero_flag == (w_reg == 8'h00)) else $error("subtract flags wrong");
    a_swap_w: assert property (go && op_code == `CRSX_OP_SWAP && !op_dest
        |=> w_reg == $past(swp) && $stable(carry_flag)) else $error("swap result wrong");
    a_xor_literal: assert property (go && op_code == `CRSX_OP_XORL
        |=> w_reg == ($past(w_reg) ^ $past(op_lit)) && $stable(carry_flag)) else $error("xor literal wrong");
    a_dir_porta: assert property (go && op_code == `CRSX_OP_DIR && op_addr[2:0] == 3'h5
        |=> port_a_direction == $past(w_reg)) else $error("direction load wrong");
    a_sleep_entry: assert property (go && op_code == `CRSX_OP_SLEEP |=> sleeping && osc_stop
        && watchdog_counter == 8'h00 && wdt_prescaler == 8'h00 && timeout_status_bit && !powerdown_status_bit)
        else $error("sleep entry wrong");
    a_sleep_hold: assert property (sleeping |=> $stable(w_reg) && !file_we)
        else $error("op executed while asleep");
endmodule // crsx_asserts

bind crsx_core crsx_asserts u_chk (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .op_dest(op_dest), .op_addr(op_addr), .op_lit(op_lit), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .w_reg(w_reg), .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag),
    .zero_flag(zero_flag), .timeout_status_bit(timeout_status_bit), .powerdown_status_bit(powerdown_status_bit),
    .watchdog_counter(watchdog_counter), .wdt_prescaler(wdt_prescaler), .port_a_direction(port_a_direction),
    .osc_stop(osc_stop), .sleeping(sleeping));

// ===== tb_crsx_core.sv
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
`include "crsx_regs.vh"
module tb_crsx_core;
    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    reg        clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, op_dest = 1'b0, wake_pin = 1'b0;
    reg  [3:0] op_code = 4'h0;
    reg  [6:0] op_addr = 7'h00;
    reg  [7:0] op_lit = 8'h00, file_rdata = 8'h00;
    wire       fwe, cf, ncf, zf, to_b, pd_b, osc_stop, sleeping;
    wire [6:0] waddr;
    wire [7:0] wdata, w_reg, wdt, presc, dir_a, dir_b, dir_c;
    reg  [7:0] w = 8'h00, r;
    reg        c = 1'b0, dc = 1'b0, z = 1'b0;
    integer    fail_count = 0, num_checks = 0, cyc = 0, i;

    crsx_core u_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .op_dest(op_dest),
        .op_addr(op_addr), .op_lit(op_lit), .file_rdata(file_rdata), .wake_pin(wake_pin), .file_we(fwe),
        .file_waddr(waddr), .file_wdata(wdata), .w_reg(w_reg), .carry_flag(cf), .nibble_carry_flag(ncf),
        .zero_flag(zf), .timeout_status_bit(to_b), .powerdown_status_bit(pd_b), .watchdog_counter(wdt),
        .wdt_prescaler(presc), .port_a_direction(dir_a), .port_b_direction(dir_b), .port_c_direction(dir_c),
        .osc_stop(osc_stop), .sleeping(sleeping));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count = fail_count + 1;
            end_sim;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input [8*8-1:0] nm, input [7:0] e, input [7:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("mismatch %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Value v feeds both the literal and the file read data
    task op(input [3:0] k, input d, input [6:0] a, input [7:0] v);
        reg [8:0] s;
        reg [4:0] h;
        reg       ci, fw;
        begin
            @(posedge clk);
            op_valid <= 1'b1;
            op_code <= k;
            op_dest <= d;
            op_addr <= a;
            op_lit <= v;
            file_rdata <= v;
            ci = (k == `CRSX_OP_SUBFB) ? c : 1'b1;
            s = v + {1'b0, ~w} + ci;
            h = v[3:0] + {1'b0, ~w[3:0]} + ci;
            fw = d;
            case (k)
                `CRSX_OP_ROR: begin
                    r = {c, v[7:1]};
                    c = v[0];
                end
                `CRSX_OP_SUBL, `CRSX_OP_SUBF, `CRSX_OP_SUBFB: begin
                    r = s[7:0];
                    {c, dc, z} = {s[8], h[4], r == 8'h00};
                    fw = d && k != `CRSX_OP_SUBL;
                end
                `CRSX_OP_SWAP: r = {v[3:0], v[7:4]};
                `CRSX_OP_XORL, `CRSX_OP_XORF: begin
                    r = w ^ v;
                    z = r == 8'h00;
                    fw = d && k == `CRSX_OP_XORF;
                end
                default: {r, fw} = {w, 1'b0};
            endcase
            if (!fw) w = r;
            @(posedge clk);
            op_valid <= 1'b0;
            #1;
            chk("w", w, w_reg);
            chk("flags", {c, dc, z}, {cf, ncf, zf});
            chk("fwe", fw, fwe);
            if (fw) chk("wdata", r, wdata);
            if (fw) chk("waddr", a, waddr);
        end
    endtask
    task t_sub;
        begin
            op(`CRSX_OP_XORL, 1'b0, 7'h00, 8'h3c);
            op(`CRSX_OP_SUBL, 1'b0, 7'h00, 8'h3c);
            op(`CRSX_OP_SUBL, 1'b0, 7'h00, 8'h00);
            op(`CRSX_OP_XORL, 1'b0, 7'h00, 8'h13);
            op(`CRSX_OP_SUBF, 1'b1, 7'h7f, 8'h12);
            op(`CRSX_OP_SUBFB, 1'b0, 7'h01, 8'h20);
            op(`CRSX_OP_SUBFB, 1'b1, 7'h02, 8'h0d);
            op(`CRSX_OP_SUBF, 1'b0, 7'h00, 8'hff);
        end
    endtask
    task t_misc;
        begin
            op(`CRSX_OP_ROR, 1'b0, 7'h10, 8'h81);
            op(`CRSX_OP_ROR, 1'b1, 7'h11, 8'h02);
            op(`CRSX_OP_SWAP, 1'b0, 7'h12, 8'ha5);
            op(`CRSX_OP_SWAP, 1'b1, 7'h13, 8'h0f);
            op(`CRSX_OP_XORF, 1'b1, 7'h14, w);
            op(`CRSX_OP_XORF, 1'b0, 7'h15, 8'h5a);
            op(`CRSX_OP_XORL, 1'b0, 7'h00, w);
        end
    endtask
    task t_dir;
        begin
            for (i = 5; i < 8; i = i + 1) begin
                op(`CRSX_OP_XORL, 1'b0, 7'h00, w ^ (8'h10 * i));
                op(`CRSX_OP_DIR, 1'b0, i, 8'h00);
            end
            op(`CRSX_OP_DIR, 1'b0, 7'h04, 8'h00);
            chk("dir_a", 8'h50, dir_a);
            chk("dir_b", 8'h60, dir_b);
            chk("dir_c", 8'h70, dir_c);
        end
    endtask
    task t_sleep;
        begin
            op(`CRSX_OP_SLEEP, 1'b0, 7'h00, 8'h00);
            chk("sleep", 8'h0e, {4'h0, sleeping, osc_stop, to_b, pd_b});
            chk("wdt", 8'h00, wdt | presc);
            @(posedge clk);
            op_valid <= 1'b1;
            op_code <= `CRSX_OP_XORL;
            op_lit <= 8'hff;
            @(posedge clk);
            op_valid <= 1'b0;
            wake_pin <= 1'b1;
            #1;
            chk("asleep_w", w, w_reg);
            chk("asleep_wd", 8'h00, wdt | presc);
            repeat (4) @(posedge clk);
            wake_pin <= 1'b0;
            op(`CRSX_OP_XORL, 1'b0, 7'h00, 8'h01);
            chk("wake", 8'h02, {4'h0, sleeping, osc_stop, to_b, pd_b});
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("rst_dir", 8'hff, dir_a & dir_b & dir_c);
        chk("rst_stat", 8'h03, {6'h00, to_b, pd_b});
        t_sub;
        t_misc;
        t_dir;
        t_sleep;
        end_sim;
    end
endmodule // tb_crsx_core
